// *** design/pin_mux_pkg.sv ***
// constants and carrier types for the peripheral interconnect multiplexer
package pin_mux_pkg;

	// option register addresses and values after reset
	localparam logic [15:0] OPT_ONE_ADDR  = 16'h3004;
	localparam logic [15:0] OPT_TWO_ADDR  = 16'h3005;
	localparam logic [7:0]  OPT_ONE_RESET = 8'h0C;
	localparam logic [7:0]  OPT_TWO_RESET = 8'h00;
	localparam logic [7:0]  READ_NONE     = 8'h00;

	// system_option_reg_one fields
	localparam int SERIAL_PIN_SELECT_BIT = 5;
	localparam int TIMER0_PIN_SELECT_BIT = 6;
	localparam int TIMER1_PIN_SELECT_BIT = 7;

	// system_option_reg_two fields
	localparam int TRIGGER_SELECT_LSB    = 0;
	localparam int COUNTER_CAPTURE_BIT   = 3;
	localparam int TX_MODULATION_BIT     = 4;
	localparam int RX_CAPTURE_BIT        = 5;
	localparam int RX_FILTER_BIT         = 6;
	localparam int CMP_TO_TIMER_BIT      = 7;

	// converter_trigger_select codes
	localparam logic [1:0] TRIG_COUNTER   = 2'h0;
	localparam logic [1:0] TRIG_CMP       = 2'h1;
	localparam logic [1:0] TRIG_TIMER     = 2'h2;
	localparam logic [1:0] TRIG_TIMER_INV = 2'h3;

	// shared pin indices
	localparam int NUM_PINS = 11;
	localparam int PIN_A0   = 0;
	localparam int PIN_A1   = 1;
	localparam int PIN_A2   = 2;
	localparam int PIN_A3   = 3;
	localparam int PIN_A5   = 4;
	localparam int PIN_B0   = 5;
	localparam int PIN_B1   = 6;
	localparam int PIN_B2   = 7;
	localparam int PIN_B3   = 8;
	localparam int PIN_B4   = 9;
	localparam int PIN_B5   = 10;

	// timer channel indices
	localparam int NUM_CH   = 4;
	localparam int CH_T0C0  = 0;
	localparam int CH_T0C1  = 1;
	localparam int CH_T1C0  = 2;
	localparam int CH_T1C1  = 3;

	typedef struct packed {
		logic [7:0] two;
		logic [7:0] one;
	} option_t;

	typedef struct packed {
		logic [NUM_PINS-1:0] out;
		logic [NUM_PINS-1:0] oe_b;
	} pins_t;

	typedef struct packed {
		pins_t             pins;
		logic              serial_rx;
		logic [NUM_CH-1:0] timer_in;
		logic              trigger;
	} mux_state_t;

	localparam mux_state_t MUX_RESET = '{
		pins: '{out: 11'h000, oe_b: 11'h7FF},
		serial_rx: 1'b1,
		timer_in: 4'h0,
		trigger: 1'b0
	};

endpackage : pin_mux_pkg

// *** design/option_regs.sv ***
// the two system option registers behind the plain register port
`timescale 1ns/10ps
module option_regs (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                rst_b,
	// register port
	input  wire logic [15:0]         reg_addr,
	input  wire logic [7:0]          reg_wdata,
	input  wire logic                reg_write,
	input  wire logic                reg_read,
	output logic [7:0]               reg_rdata,
	// select bits toward the routing logic
	output pin_mux_pkg::option_t     opt,
	output pin_mux_pkg::option_t     next_opt
);

	typedef struct packed {
		pin_mux_pkg::option_t opt;
		logic [7:0]           rdata;
	} regs_state_t;

	regs_state_t state;
	regs_state_t next_state;

	always_comb begin
		next_state = state;
		next_state.rdata = pin_mux_pkg::READ_NONE;
		if (reg_write && reg_addr == pin_mux_pkg::OPT_ONE_ADDR) begin
			next_state.opt.one = reg_wdata;
		end
		if (reg_write && reg_addr == pin_mux_pkg::OPT_TWO_ADDR) begin
			next_state.opt.two = reg_wdata;
		end
		// unmapped reads answer zero
		if (reg_read && reg_addr == pin_mux_pkg::OPT_ONE_ADDR) begin
			next_state.rdata = state.opt.one;
		end
		if (reg_read && reg_addr == pin_mux_pkg::OPT_TWO_ADDR) begin
			next_state.rdata = state.opt.two;
		end
		if (!rst_b) begin
			next_state.opt.one = pin_mux_pkg::OPT_ONE_RESET;
			next_state.opt.two = pin_mux_pkg::OPT_TWO_RESET;
			next_state.rdata   = pin_mux_pkg::READ_NONE;
		end
	end

	always_ff @(posedge clk) begin
		state <= next_state;
	end

	assign opt       = state.opt;
	assign next_opt  = next_state.opt;
	assign reg_rdata = state.rdata;

	a_reset_values: assert property (@(posedge clk) !rst_b |=>
		opt.one == pin_mux_pkg::OPT_ONE_RESET && opt.two == pin_mux_pkg::OPT_TWO_RESET)
		else $error("option registers not at reset value");

	a_read_back: assert property (@(posedge clk) disable iff (!rst_b)
		reg_read && reg_addr == pin_mux_pkg::OPT_TWO_ADDR |=> reg_rdata == $past(opt.two))
		else $error("option register two read back wrong");

endmodule : option_regs

// *** design/peripheral_interconnect_mux.sv ***
// pin placement and module-to-module routing for serial port, timers and comparator
`timescale 1ns/10ps
module peripheral_interconnect_mux #(
	parameter int TRIG_CHANNEL = 0
) (
	// clock and reset
	input  wire logic                             clk,
	input  wire logic                             rst_b,
	// register port
	input  wire logic [15:0]                      reg_addr,
	input  wire logic [7:0]                       reg_wdata,
	input  wire logic                             reg_write,
	input  wire logic                             reg_read,
	output logic [7:0]                            reg_rdata,
	// shared pins
	input  wire logic [pin_mux_pkg::NUM_PINS-1:0] pin_in,
	output logic [pin_mux_pkg::NUM_PINS-1:0]      pin_out,
	output logic [pin_mux_pkg::NUM_PINS-1:0]      pin_oe_b,
	// general port fallback
	input  wire logic [pin_mux_pkg::NUM_PINS-1:0] gpio_out,
	input  wire logic [pin_mux_pkg::NUM_PINS-1:0] gpio_oe_b,
	// serial_port_zero
	input  wire logic                             serial_tx_data,
	output logic                                  serial_rx_data,
	// timer_zero and timer_one channels
	input  wire logic [pin_mux_pkg::NUM_CH-1:0]   timer_out,
	input  wire logic [pin_mux_pkg::NUM_CH-1:0]   timer_out_en,
	input  wire logic [pin_mux_pkg::NUM_CH-1:0]   timer_capture_mode,
	output logic [pin_mux_pkg::NUM_CH-1:0]        timer_in,
	// analog_comparator, counter overflow, converter trigger
	input  wire logic                             comparator_out,
	input  wire logic                             counter_overflow,
	output logic                                  converter_trigger
);

	pin_mux_pkg::option_t    opt;
	pin_mux_pkg::option_t    next_opt;
	pin_mux_pkg::mux_state_t state;
	pin_mux_pkg::mux_state_t next_state;

	option_regs u_regs (
		.clk       (clk),
		.rst_b     (rst_b),
		.reg_addr  (reg_addr),
		.reg_wdata (reg_wdata),
		.reg_write (reg_write),
		.reg_read  (reg_read),
		.reg_rdata (reg_rdata),
		.opt       (opt),
		.next_opt  (next_opt)
	);

	logic                             serial_pin_select;
	logic                             timer0_pin_select;
	logic                             timer1_pin_select;
	logic                             comparator_to_timer_select;
	logic                             transmit_modulation_enable;
	logic                             receive_capture_enable;
	logic                             receive_filter_enable;
	logic                             counter_overflow_capture;
	logic [1:0]                       converter_trigger_select;
	logic [pin_mux_pkg::NUM_PINS-1:0] owned;
	logic [pin_mux_pkg::NUM_PINS-1:0] drive;
	logic [pin_mux_pkg::NUM_PINS-1:0] value;
	logic [pin_mux_pkg::NUM_CH-1:0]   released;
	logic                             trig_from_timer;
	int                               rx_pin;
	int                               tx_pin;
	int                               ch_pin [pin_mux_pkg::NUM_CH];

	// selects come from next_opt so the write edge already moves the pins
	always_comb begin
		serial_pin_select          = next_opt.one[pin_mux_pkg::SERIAL_PIN_SELECT_BIT];
		timer0_pin_select          = next_opt.one[pin_mux_pkg::TIMER0_PIN_SELECT_BIT];
		timer1_pin_select          = next_opt.one[pin_mux_pkg::TIMER1_PIN_SELECT_BIT];
		comparator_to_timer_select = next_opt.two[pin_mux_pkg::CMP_TO_TIMER_BIT];
		transmit_modulation_enable = next_opt.two[pin_mux_pkg::TX_MODULATION_BIT];
		receive_capture_enable     = next_opt.two[pin_mux_pkg::RX_CAPTURE_BIT];
		receive_filter_enable      = next_opt.two[pin_mux_pkg::RX_FILTER_BIT];
		counter_overflow_capture   = next_opt.two[pin_mux_pkg::COUNTER_CAPTURE_BIT];
		converter_trigger_select   = next_opt.two[pin_mux_pkg::TRIGGER_SELECT_LSB +: 2];
	end

	always_comb begin
		owned      = '0;
		drive      = '0;
		value      = '0;
		next_state = state;

		// placement
		rx_pin = serial_pin_select ? pin_mux_pkg::PIN_A2 : pin_mux_pkg::PIN_B0;
		tx_pin = serial_pin_select ? pin_mux_pkg::PIN_A3 : pin_mux_pkg::PIN_B1;
		ch_pin[pin_mux_pkg::CH_T0C0] = timer0_pin_select ?
			pin_mux_pkg::PIN_B2 : pin_mux_pkg::PIN_A0;
		ch_pin[pin_mux_pkg::CH_T0C1] = timer0_pin_select ?
			pin_mux_pkg::PIN_B3 : pin_mux_pkg::PIN_A1;
		ch_pin[pin_mux_pkg::CH_T1C0] = timer1_pin_select ?
			pin_mux_pkg::PIN_A5 : pin_mux_pkg::PIN_B4;
		ch_pin[pin_mux_pkg::CH_T1C1] = pin_mux_pkg::PIN_B5;

		// a channel whose internal route is on gives its pin away
		released = '0;
		released[pin_mux_pkg::CH_T0C0] = transmit_modulation_enable;
		released[pin_mux_pkg::CH_T0C1] = receive_capture_enable;
		released[pin_mux_pkg::CH_T1C0] = comparator_to_timer_select;
		released[pin_mux_pkg::CH_T1C1] = counter_overflow_capture;
		trig_from_timer = converter_trigger_select[1] && !timer_capture_mode[TRIG_CHANNEL];
		if (trig_from_timer) begin
			released[TRIG_CHANNEL] = 1'b1;
		end

		// serial receive pin is observed unless the filter takes over
		if (!receive_filter_enable) begin
			owned[rx_pin] = 1'b1;
		end
		owned[tx_pin] = 1'b1;
		drive[tx_pin] = 1'b1;
		if (transmit_modulation_enable) begin
			value[tx_pin] = serial_tx_data & timer_out[pin_mux_pkg::CH_T0C0];
		end else begin
			value[tx_pin] = serial_tx_data;
		end

		// timer channels claim their pins only while not released
		for (int c = 0; c < pin_mux_pkg::NUM_CH; c++) begin
			if (!released[c]) begin
				owned[ch_pin[c]] = 1'b1;
				drive[ch_pin[c]] = timer_out_en[c];
				value[ch_pin[c]] = timer_out[c];
			end
		end

		// receive path into serial port
		next_state.serial_rx = receive_filter_enable ? comparator_out : pin_in[rx_pin];

		// capture inputs, a released pin is no longer observed
		for (int c = 0; c < pin_mux_pkg::NUM_CH; c++) begin
			next_state.timer_in[c] = released[c] ? 1'b0 : pin_in[ch_pin[c]];
		end
		if (comparator_to_timer_select) begin
			next_state.timer_in[pin_mux_pkg::CH_T1C0] = comparator_out;
		end
		if (receive_capture_enable) begin
			if (receive_filter_enable) begin
				next_state.timer_in[pin_mux_pkg::CH_T0C1] = comparator_out;
			end else begin
				next_state.timer_in[pin_mux_pkg::CH_T0C1] = pin_in[rx_pin];
			end
		end
		if (counter_overflow_capture) begin
			next_state.timer_in[pin_mux_pkg::CH_T1C1] = counter_overflow;
		end

		// converter hardware trigger; a capture-mode channel holds its idle level
		case (converter_trigger_select)
			pin_mux_pkg::TRIG_COUNTER: begin
				next_state.trigger = counter_overflow;
			end
			pin_mux_pkg::TRIG_CMP: begin
				next_state.trigger = comparator_out;
			end
			pin_mux_pkg::TRIG_TIMER: begin
				next_state.trigger = trig_from_timer && timer_out[TRIG_CHANNEL];
			end
			pin_mux_pkg::TRIG_TIMER_INV: begin
				next_state.trigger = !(trig_from_timer && timer_out[TRIG_CHANNEL]);
			end
			default: begin
				next_state.trigger = 1'b0;
			end
		endcase

		// unclaimed pins fall back to the general port
		for (int p = 0; p < pin_mux_pkg::NUM_PINS; p++) begin
			next_state.pins.out[p]  = owned[p] ? value[p] : gpio_out[p];
			next_state.pins.oe_b[p] = owned[p] ? !drive[p] : gpio_oe_b[p];
		end

		if (!rst_b) begin
			next_state = pin_mux_pkg::MUX_RESET;
		end
	end

	always_ff @(posedge clk) begin
		state <= next_state;
	end

	assign pin_out           = state.pins.out;
	assign pin_oe_b          = state.pins.oe_b;
	assign serial_rx_data    = state.serial_rx;
	assign timer_in          = state.timer_in;
	assign converter_trigger = state.trigger;

	// outputs at an edge reflect opt after that edge and inputs before it
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_write_two;
		reg_write && reg_addr == pin_mux_pkg::OPT_TWO_ADDR;
	endsequence

	sequence s_live;
		$past(rst_b);
	endsequence

	a_serial_default: assert property (
		s_live and !opt.one[pin_mux_pkg::SERIAL_PIN_SELECT_BIT] |->
		pin_oe_b[pin_mux_pkg::PIN_B1] == 1'b0 &&
		(opt.two[pin_mux_pkg::TX_MODULATION_BIT] ||
		pin_out[pin_mux_pkg::PIN_B1] == $past(serial_tx_data)))
		else $error("serial transmit not on default pin");

	a_serial_moved: assert property (
		s_live and opt.one[pin_mux_pkg::SERIAL_PIN_SELECT_BIT] &&
		!opt.two[pin_mux_pkg::TX_MODULATION_BIT] |->
		pin_out[pin_mux_pkg::PIN_A3] == $past(serial_tx_data) &&
		pin_out[pin_mux_pkg::PIN_B1] == $past(gpio_out[pin_mux_pkg::PIN_B1]))
		else $error("serial transmit not on moved pin");

	a_timer0_place: assert property (
		s_live and !opt.one[pin_mux_pkg::TIMER0_PIN_SELECT_BIT] &&
		!opt.two[pin_mux_pkg::TX_MODULATION_BIT] &&
		!opt.two[pin_mux_pkg::TRIGGER_SELECT_LSB + 1] |->
		pin_out[pin_mux_pkg::PIN_A0] == $past(timer_out[pin_mux_pkg::CH_T0C0]))
		else $error("timer zero channel 0 not on its pin");

	a_timer1_place: assert property (
		s_live and opt.one[pin_mux_pkg::TIMER1_PIN_SELECT_BIT] &&
		!opt.two[pin_mux_pkg::CMP_TO_TIMER_BIT] |->
		pin_out[pin_mux_pkg::PIN_A5] == $past(timer_out[pin_mux_pkg::CH_T1C0]))
		else $error("timer one channel 0 not on moved pin");

	a_cmp_to_timer: assert property (
		s_live and opt.two[pin_mux_pkg::CMP_TO_TIMER_BIT] |->
		timer_in[pin_mux_pkg::CH_T1C0] == $past(comparator_out))
		else $error("comparator not routed to timer one");

	a_tx_mod_gate: assert property (
		s_live and !opt.one[pin_mux_pkg::SERIAL_PIN_SELECT_BIT] |->
		pin_out[pin_mux_pkg::PIN_B1] == ($past(serial_tx_data) &&
		(!opt.two[pin_mux_pkg::TX_MODULATION_BIT] ||
		$past(timer_out[pin_mux_pkg::CH_T0C0]))))
		else $error("transmit modulation wrong");

	a_t0c0_release: assert property (
		s_live and opt.two[pin_mux_pkg::TX_MODULATION_BIT] &&
		!opt.one[pin_mux_pkg::TIMER0_PIN_SELECT_BIT] |->
		pin_oe_b[pin_mux_pkg::PIN_A0] == $past(gpio_oe_b[pin_mux_pkg::PIN_A0]))
		else $error("timer zero channel 0 pin not released");

	a_rx_capture: assert property (
		s_live and opt.two[pin_mux_pkg::RX_CAPTURE_BIT] |->
		timer_in[pin_mux_pkg::CH_T0C1] == serial_rx_data)
		else $error("receive capture not joined to timer");

	a_rx_filter: assert property (
		s_live and opt.two[pin_mux_pkg::RX_FILTER_BIT] |->
		serial_rx_data == $past(comparator_out) &&
		pin_oe_b[pin_mux_pkg::PIN_B0] == $past(gpio_oe_b[pin_mux_pkg::PIN_B0]))
		else $error("receive filter routing wrong");

	a_rtc_capture: assert property (
		s_live and opt.two[pin_mux_pkg::COUNTER_CAPTURE_BIT] |->
		timer_in[pin_mux_pkg::CH_T1C1] == $past(counter_overflow))
		else $error("counter overflow not captured");

	a_trig_select: assert property (
		s_live and opt.two[1:0] == pin_mux_pkg::TRIG_CMP |->
		converter_trigger == $past(comparator_out))
		else $error("converter trigger not from comparator");

	a_trig_capture: assert property (
		s_live and opt.two[1:0] == pin_mux_pkg::TRIG_TIMER &&
		$past(timer_capture_mode[TRIG_CHANNEL]) |-> !converter_trigger)
		else $error("trigger from capture-mode channel");

	a_write_now: assert property (
		s_write_two ##0 reg_wdata[pin_mux_pkg::RX_FILTER_BIT] |=>
		serial_rx_data == $past(comparator_out))
		else $error("filter route late after write");

endmodule : peripheral_interconnect_mux

// *** test/pad_model.sv ***
// pad model: resolves the level of each shared pin seen by the mux
`timescale 1ns/10ps
module pad_model (
	// mux side
	input  wire logic [pin_mux_pkg::NUM_PINS-1:0] pin_out,
	input  wire logic [pin_mux_pkg::NUM_PINS-1:0] pin_oe_b,
	output logic [pin_mux_pkg::NUM_PINS-1:0]      pin_in,
	// outside drivers
	input  wire logic [pin_mux_pkg::NUM_PINS-1:0] ext_val,
	input  wire logic [pin_mux_pkg::NUM_PINS-1:0] ext_en
);
	// undriven pads float up through the pull-up, never to a stale level
	always_comb begin
		for (int i = 0; i < pin_mux_pkg::NUM_PINS; i++) begin
			pin_in[i] = !pin_oe_b[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
		end
	end
endmodule : pad_model

// *** test/peripheral_interconnect_mux_tb.sv ***
// self-checking bench for the peripheral interconnect multiplexer
`timescale 1ns/10ps
module peripheral_interconnect_mux_tb;
	logic        clk;
	logic        rst_b;
	logic [15:0] reg_addr;
	logic [7:0]  reg_wdata;
	logic        reg_write;
	logic        reg_read;
	logic [7:0]  reg_rdata;
	logic [10:0] pin_in;
	logic [10:0] pin_out;
	logic [10:0] pin_oe_b;
	logic [10:0] gpio_out;
	logic [10:0] gpio_oe_b;
	logic [10:0] ext_val;
	logic [10:0] ext_en;
	logic        serial_tx_data;
	logic        serial_rx_data;
	logic [3:0]  timer_out;
	logic [3:0]  timer_out_en;
	logic [3:0]  timer_capture_mode;
	logic [3:0]  timer_in;
	logic        comparator_out;
	logic        counter_overflow;
	logic        converter_trigger;
	int          num_errors;
	int          checks;
	int          cycles;

	peripheral_interconnect_mux dut_u (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_write,
		.reg_read, .reg_rdata, .pin_in, .pin_out, .pin_oe_b, .gpio_out, .gpio_oe_b,
		.serial_tx_data, .serial_rx_data, .timer_out, .timer_out_en, .timer_capture_mode,
		.timer_in, .comparator_out, .counter_overflow, .converter_trigger);
	pad_model pad_u (.pin_out, .pin_oe_b, .pin_in, .ext_val, .ext_en);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ceiling well above the roughly two hundred cycles the scenarios need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			$display("CHECK FAILED at %0t ns: timeout", $time);
			finish_test;
		end
	end

	task automatic finish_test;
		if (num_errors == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test

	task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t ns: %s", $time, m);
		end
	endtask : chk

	// one edge to sample the inputs, then look once outputs settled
	task automatic go;
		@(posedge clk);
		#1;
	endtask : go

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1;
		chk(reg_rdata, e, "read data");
		go;
		chk(reg_rdata, 8'h00, "read data held");
	endtask : rd

	task automatic drv(input int p, input logic v);
		chk(pin_oe_b[p], 1'b0, "pin not driven");
		chk(pin_out[p], v, "pin level");
	endtask : drv

	task automatic freed(input int p);
		chk(pin_oe_b[p], gpio_oe_b[p], "freed pin enable");
		chk(pin_out[p], gpio_out[p], "freed pin level");
	endtask : freed

	task automatic t_regs;
		rd(pin_mux_pkg::OPT_ONE_ADDR, pin_mux_pkg::OPT_ONE_RESET);
		rd(pin_mux_pkg::OPT_TWO_ADDR, pin_mux_pkg::OPT_TWO_RESET);
		wr(pin_mux_pkg::OPT_ONE_ADDR, 8'hA5);
		wr(pin_mux_pkg::OPT_TWO_ADDR, 8'h5A);
		wr(16'h3006, 8'hFF);
		rd(pin_mux_pkg::OPT_ONE_ADDR, 8'hA5);
		rd(pin_mux_pkg::OPT_TWO_ADDR, 8'h5A);
		rd(16'h3006, pin_mux_pkg::READ_NONE);
		wr(pin_mux_pkg::OPT_ONE_ADDR, 8'h0C);
		wr(pin_mux_pkg::OPT_TWO_ADDR, 8'h00);
	endtask : t_regs

	task automatic t_serial;
		int rxp;
		int txp;
		for (int s = 0; s < 2; s++) begin
			wr(pin_mux_pkg::OPT_ONE_ADDR, s ? 8'h2C : 8'h0C);
			rxp = s ? pin_mux_pkg::PIN_A2 : pin_mux_pkg::PIN_B0;
			txp = s ? pin_mux_pkg::PIN_A3 : pin_mux_pkg::PIN_B1;
			for (int v = 0; v < 2; v++) begin
				@(posedge clk);
				serial_tx_data <= v[0];
				ext_val        <= v ? 11'h1 << rxp : ~(11'h1 << rxp);
				go;
				drv(txp, v[0]);
				chk(pin_oe_b[rxp], 1'b1, "receive pin driven");
				chk(serial_rx_data, v[0], "receive data");
				chk(timer_in[1], 1'b0, "receive fed to timer");
				freed(s ? pin_mux_pkg::PIN_B0 : pin_mux_pkg::PIN_A2);
				freed(s ? pin_mux_pkg::PIN_B1 : pin_mux_pkg::PIN_A3);
			end
		end
		wr(pin_mux_pkg::OPT_ONE_ADDR, 8'h0C);
	endtask : t_serial

	task automatic t_timers;
		for (int s = 0; s < 4; s++) begin
			wr(pin_mux_pkg::OPT_ONE_ADDR, 8'h0C | 8'(s << 6));
			for (int v = 0; v < 2; v++) begin
				@(posedge clk);
				timer_out <= v ? 4'h5 : 4'hA;
				go;
				drv(s[0] ? pin_mux_pkg::PIN_B2 : pin_mux_pkg::PIN_A0, timer_out[0]);
				drv(s[0] ? pin_mux_pkg::PIN_B3 : pin_mux_pkg::PIN_A1, timer_out[1]);
				drv(s[1] ? pin_mux_pkg::PIN_A5 : pin_mux_pkg::PIN_B4, timer_out[2]);
				drv(pin_mux_pkg::PIN_B5, timer_out[3]);
				freed(s[0] ? pin_mux_pkg::PIN_A0 : pin_mux_pkg::PIN_B2);
				freed(s[1] ? pin_mux_pkg::PIN_B4 : pin_mux_pkg::PIN_A5);
			end
		end
		wr(pin_mux_pkg::OPT_ONE_ADDR, 8'h0C);
	endtask : t_timers

	task automatic t_mod;
		wr(pin_mux_pkg::OPT_TWO_ADDR, 8'h10);
		for (int i = 0; i < 8; i++) begin
			if (i == 4) begin
				wr(pin_mux_pkg::OPT_ONE_ADDR, 8'h4C);
			end
			@(posedge clk);
			serial_tx_data <= i[0];
			timer_out      <= {3'h0, i[1]};
			go;
			drv(pin_mux_pkg::PIN_B1, i[0] & i[1]);
			freed(i[2] ? pin_mux_pkg::PIN_B2 : pin_mux_pkg::PIN_A0);
			chk(timer_in[0], 1'b0, "released channel observed");
		end
		wr(pin_mux_pkg::OPT_ONE_ADDR, 8'h0C);
		wr(pin_mux_pkg::OPT_TWO_ADDR, 8'h00);
	endtask : t_mod

	task automatic t_rx;
		for (int m = 1; m < 4; m++) begin
			wr(pin_mux_pkg::OPT_TWO_ADDR, 8'(m << 5));
			for (int v = 0; v < 2; v++) begin
				@(posedge clk);
				ext_val        <= v ? 11'h7FF : 11'h000;
				comparator_out <= !v[0];
				go;
				chk(serial_rx_data, m[1] ? !v[0] : v[0], "receive source");
				chk(timer_in[1], m[0] & (m[1] ? !v[0] : v[0]), "capture src");
				if (m[1]) freed(pin_mux_pkg::PIN_B0);
				else chk(pin_oe_b[pin_mux_pkg::PIN_B0], 1'b1, "receive pin driven");
				if (m[0]) freed(pin_mux_pkg::PIN_A1);
			end
		end
	endtask : t_rx

	task automatic t_route;
		for (int s = 0; s < 2; s++) begin
			wr(pin_mux_pkg::OPT_ONE_ADDR, s ? 8'h8C : 8'h0C);
			wr(pin_mux_pkg::OPT_TWO_ADDR, 8'h88);
			for (int v = 0; v < 2; v++) begin
				@(posedge clk);
				comparator_out   <= v[0];
				counter_overflow <= !v[0];
				go;
				chk(timer_in[2], v[0], "comparator to channel");
				chk(timer_in[3], !v[0], "overflow to channel");
				freed(s ? pin_mux_pkg::PIN_A5 : pin_mux_pkg::PIN_B4);
				freed(pin_mux_pkg::PIN_B5);
			end
		end
		wr(pin_mux_pkg::OPT_ONE_ADDR, 8'h0C);
	endtask : t_route

	task automatic t_trig;
		logic e;
		for (int c = 0; c < 4; c++) begin
			wr(pin_mux_pkg::OPT_TWO_ADDR, 8'(c));
			for (int v = 0; v < 4; v++) begin
				@(posedge clk);
				counter_overflow <= v[0];
				comparator_out   <= v[1];
				timer_out        <= {3'h0, v[0] ^ v[1]};
				go;
				case (c)
					0: e = v[0];
					1: e = v[1];
					2: e = v[0] ^ v[1];
					default: e = !(v[0] ^ v[1]);
				endcase
				chk(converter_trigger, e, "trigger source");
				if (c > 1) freed(pin_mux_pkg::PIN_A0);
				else drv(pin_mux_pkg::PIN_A0, v[0] ^ v[1]);
			end
		end
		// trigger channel put in capture mode on purpose to see the trigger held
		@(posedge clk);
		timer_out_en       <= 4'hE;
		timer_capture_mode <= 4'h1;
		for (int c = 2; c < 4; c++) begin
			wr(pin_mux_pkg::OPT_TWO_ADDR, 8'(c));
			for (int v = 0; v < 2; v++) begin
				@(posedge clk);
				timer_out <= {3'h0, v[0]};
				go;
				chk(converter_trigger, c == 3, "trigger in capture");
				chk(pin_oe_b[pin_mux_pkg::PIN_A0], 1'b1, "capture pin driven");
				chk(timer_in[0], ext_val[pin_mux_pkg::PIN_A0], "capture pin input");
			end
		end
	endtask : t_trig

	initial begin
		rst_b              = 1'b0;
		reg_addr           = 16'h0000;
		reg_wdata          = 8'h00;
		reg_write          = 1'b0;
		reg_read           = 1'b0;
		gpio_out           = 11'h555;
		gpio_oe_b          = 11'h380; // mixed, so a freed pin differs from a claimed one
		ext_val            = 11'h000;
		ext_en             = 11'h7FF;
		serial_tx_data     = 1'b1;
		timer_out          = 4'h0;
		timer_out_en       = 4'hF;
		timer_capture_mode = 4'h0; // trigger channel starts out of capture mode
		comparator_out     = 1'b0;
		counter_overflow   = 1'b0;
		repeat (11) @(posedge clk);
		#1;
		chk(pin_oe_b, 11'h7FF, "reset pin enables");
		chk(serial_rx_data, 1'b1, "reset receive");
		@(posedge clk);
		rst_b <= 1'b1;
		t_regs;
		t_serial;
		t_timers;
		t_mod;
		t_rx;
		t_route;
		t_trig;
		finish_test;
	end
endmodule : peripheral_interconnect_mux_tb
